// ---- ifc_pkg.sv ----
// Shared constants, field layouts and types of the gated frequency counter
package ifc_pkg;

   // **************************************************
   // Register bus and map
   // **************************************************
   localparam int ADDR_W = 8;                          // Register address width
   localparam int DATA_W = 8;                          // Register data width
   localparam logic [ADDR_W-1:0] ADR_MODE = 8'hf4;     // Mode / control register
   localparam logic [ADDR_W-1:0] ADR_CNT_HI = 8'hf5;   // Count bits 18..16
   localparam logic [ADDR_W-1:0] ADR_CNT_MID = 8'hf6;  // Count bits 15..8
   localparam logic [ADDR_W-1:0] ADR_CNT_LO = 8'hf7;   // Count bits 7..0
   localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;      // Read data outside a read answer

   // **************************************************
   // Mode register fields
   // **************************************************
   localparam int BIT_JUDGE = 7;                       // Judge flag, read only
   localparam int BIT_START = 6;                       // Start / stop
   localparam int BIT_CLEAR = 5;                       // Clear count, self clearing
   localparam int GATE_LSB = 2;                        // Gate time field low bit
   localparam int GATE_W = 3;                          // Gate time field width
   localparam int SEL_LSB = 0;                         // Input select field low bit
   localparam int SEL_W = 2;                           // Input select field width
   localparam logic [GATE_W-1:0] GATE_RST = 3'h0;      // Gate field after reset
   localparam logic [SEL_W-1:0] SEL_RST = 2'h0;        // Inputs disabled after reset

   // Gate time codes
   localparam logic [GATE_W-1:0] GT_8MS = 3'h0;
   localparam logic [GATE_W-1:0] GT_32MS = 3'h1;
   localparam logic [GATE_W-1:0] GT_128MS = 3'h2;
   localparam logic [GATE_W-1:0] GT_SOFT = 3'h3;
   localparam logic [GATE_W-1:0] GT_1MS = 3'h4;
   localparam logic [GATE_W-1:0] GT_4MS = 3'h5;

   // Input select codes; upper bit low disables both pins
   localparam int SEL_ON_BIT = 1;
   localparam logic [SEL_W-1:0] SEL_FM = 2'h2;
   localparam logic [SEL_W-1:0] SEL_AM = 2'h3;

   // **************************************************
   // Count result
   // **************************************************
   localparam int CNT_W = 19;                          // Result width
   localparam logic [3:0] HI_FILL = 4'hf;              // Unused top bits of high byte
   localparam int FM_DIV_W = 2;                        // Prescaler width, divide by four
   localparam logic [FM_DIV_W-1:0] FM_DIV_LAST = 2'h3; // Prescaler terminal value

   // **************************************************
   // Timing
   // **************************************************
   localparam int CLK_PERIOD_NS = 25;                  // 40 MHz system clock
   localparam int REF_PERIOD_NS = 1000000;             // 1 kHz gate reference
   localparam int REF_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICKS_W = 8;                         // Enough for 128 ms
   localparam int GATE_8_MS = 8;
   localparam int GATE_32_MS = 32;
   localparam int GATE_128_MS = 128;
   localparam int GATE_1_MS = 1;
   localparam int GATE_4_MS = 4;
   localparam int REF_MS = 1;                          // One reference period in ms

   // One-hot gate sequencer states
   typedef enum logic [3:0] {
      G_IDLE = 4'b0001,
      G_WAIT = 4'b0010,
      G_OPEN = 4'b0100,
      G_SOFT = 4'b1000
   } ifc_gate_t;

   // Gate length in reference periods; zero for reserved or soft codes
   function automatic logic [TICKS_W-1:0] gate_ticks(input logic [GATE_W-1:0] code);
      unique case (code)
         GT_8MS: gate_ticks = TICKS_W'(GATE_8_MS / REF_MS);
         GT_32MS: gate_ticks = TICKS_W'(GATE_32_MS / REF_MS);
         GT_128MS: gate_ticks = TICKS_W'(GATE_128_MS / REF_MS);
         GT_1MS: gate_ticks = TICKS_W'(GATE_1_MS / REF_MS);
         GT_4MS: gate_ticks = TICKS_W'(GATE_4_MS / REF_MS);
         default: gate_ticks = '0;
      endcase
   endfunction : gate_ticks

endpackage : ifc_pkg

// ---- ifc_edge_if.sv ----
// Carrier between the counter core and its input edge front end
`timescale 1ns/1ps
interface ifc_edge_if;
   import ifc_pkg::*;
   logic [SEL_W-1:0] sel;   // Input select field
   logic clr;               // Clear pulse, also resets the prescaler
   logic cnt_pulse;         // One count event

   modport core (output sel, output clr, input cnt_pulse);
   modport front (input sel, input clr, output cnt_pulse);
endinterface : ifc_edge_if

// ---- ifc_edge.sv ----
// Input pin synchronisers, pin select and FM prescaler
`timescale 1ns/1ps
module ifc_edge
(
   input wire logic clk,
   input wire logic rst,
   input wire logic fm_pin,
   input wire logic am_pin,
   ifc_edge_if.front eif
);
   import ifc_pkg::*;

   // **************************************************
   // Synchronisers
   // **************************************************
   logic fm_s1_r, fm_s2_r, fm_s3_r; // FM pin stages
   logic am_s1_r, am_s2_r, am_s3_r; // AM pin stages
   logic [FM_DIV_W-1:0] div_r;      // Divide-by-four prescaler
   logic pulse_r;                   // Registered count event
   logic fm_rise;
   logic am_rise;

   // Two flops before use; third flop only feeds the edge detector
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         {fm_s1_r, fm_s2_r, fm_s3_r} <= 3'h0;
         {am_s1_r, am_s2_r, am_s3_r} <= 3'h0;
      end
      else
      begin
         fm_s1_r <= fm_pin;
         fm_s2_r <= fm_s1_r;
         fm_s3_r <= fm_s2_r;
         am_s1_r <= am_pin;
         am_s2_r <= am_s1_r;
         am_s3_r <= am_s2_r;
      end
   end

   // Rising edges only; input must be slower than half of CLK
   assign fm_rise = fm_s2_r & ~fm_s3_r;
   assign am_rise = am_s2_r & ~am_s3_r;

   // **************************************************
   // Prescaler and pin select
   // **************************************************
   // FM edges pass through a modulo-four counter
   always_ff @(posedge clk)
   begin
      if (rst || eif.clr)
         div_r <= '0;
      else if (eif.sel == SEL_FM && fm_rise)
         div_r <= div_r + FM_DIV_W'(1); // see RL11
   end

   // One event per counted edge; disabled pins give none
   always_ff @(posedge clk)
   begin
      if (rst)
         pulse_r <= 1'b0;
      else
         unique case (eif.sel)
            SEL_FM: pulse_r <= fm_rise && div_r == FM_DIV_LAST; // see RL11
            SEL_AM: pulse_r <= am_rise; // see RL12
            default: pulse_r <= 1'b0; // see RL18
         endcase
   end

   assign eif.cnt_pulse = pulse_r;

   // **************************************************
   // Checks
   // **************************************************
   property p_fm_div;
      @(posedge clk) disable iff (rst)
      (eif.sel == SEL_FM && $past(eif.sel) == SEL_FM && pulse_r) |-> $past(div_r) == FM_DIV_LAST;
   endproperty
   a_fm_div: assert property (p_fm_div) else $error("FM event without full prescale"); // see RL11

   property p_am_direct;
      @(posedge clk) disable iff (rst)
      (eif.sel == SEL_AM && am_rise) |=> pulse_r;
   endproperty
   a_am_direct: assert property (p_am_direct) else $error("AM edge not counted"); // see RL12

   property p_disabled;
      @(posedge clk) disable iff (rst)
      !eif.sel[SEL_ON_BIT] |=> !pulse_r;
   endproperty
   a_disabled: assert property (p_disabled) else $error("Event with inputs disabled"); // see RL18

endmodule : ifc_edge

// ---- ifc_top.sv ----
// Gated frequency counter core with register port and gate sequencer
// Overview of operation
// [RL1] Count is 19 bits, low byte bits 0-7
// [RL2] Unused four high result bits read ones
// [RL3] Software selects setup, clears, then starts
// [RL4] Clear bit zeroes all count bits
// [RL5] Fixed gate opens at next reference edge
// [RL6] Soft gate opens at once
// [RL7] Start write sets judge flag at once; a start written while the soft gate runs leaves it unchanged
// [RL8] Fixed gate expiry closes gate, clears judge
// [RL9] Soft gate never clears judge by itself
// [RL10] Open gate counts selected input rising edges
// [RL11] FM input divided by four before counting
// [RL12] AM input counted undivided
// [RL13] Gate close neither adds nor drops counts
// [RL14] Gate timing divided from system clock
// [RL15] Software waits settling after pin select
// [RL16] Software writes zeros to reserved bits
// [RL17] Gate code picks 8/32/128/soft/1/4 ms
// [RL18] Select field: off, FM, or AM
// [RL19] Mode read or interrupt entry clears judge
// [RL20] Result bytes read only, writes ignored
`timescale 1ns/1ps
module ifc_top
#(
   parameter int REF_CYCLES_P = ifc_pkg::REF_CYCLES // Clock cycles per 1 kHz reference period
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [ifc_pkg::ADDR_W-1:0] ADDR,
   input wire logic [ifc_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [ifc_pkg::DATA_W-1:0] RDATA,
   input wire logic FM_IN,
   input wire logic AM_IN,
   input wire logic IRQ_ENTER,
   output logic FM_EN,
   output logic AM_EN,
   output logic GATE
);
   import ifc_pkg::*;

   localparam int REF_W = $clog2(REF_CYCLES_P); // Reference divider width

   // Refuse a divider that cannot produce a pulse
   if (REF_CYCLES_P < 2)
   begin : g_bad_ref
      $error("REF_CYCLES_P must be at least 2");
   end

   // **************************************************
   // Declarations
   // **************************************************
   ifc_gate_t state_r;                 // Gate sequencer state
   ifc_gate_t state_nxt;               // Its next value
   logic [REF_W-1:0] ref_cnt_r;        // Reference divider
   logic tick_r;                       // 1 kHz reference rising edge
   logic [GATE_W-1:0] gate_r;          // Gate time field
   logic [SEL_W-1:0] sel_r;            // Input select field
   logic judge_r;                      // Counting in progress flag
   logic [TICKS_W-1:0] left_r;         // Reference periods left in gate
   logic [TICKS_W-1:0] left_nxt;       // Its next value
   logic [CNT_W-1:0] cnt_r;            // Count result
   logic clr_r;                        // Clear pulse toward front end
   logic open_r;                       // Gate open
   logic fm_en_r, am_en_r;             // Pin amplifier enables
   logic [DATA_W-1:0] rdata_r;         // Read answer
   logic wr_mode, rd_mode;             // Mode register strobes
   logic start_wr, stop_wr, clr_wr;    // Decoded control writes
   logic [GATE_W-1:0] wgate;           // Gate code being written
   logic expire;                       // Fixed gate ends this cycle
   logic [TICKS_W-1:0] seen_r;         // Periods seen in open gate, for checks
   logic [GATE_W-1:0] run_code_r;      // Gate code of the running measurement

   ifc_edge_if eif ();                 // Core to front end carrier

   // **************************************************
   // Register decode
   // **************************************************
   // Only the mode register accepts writes; result bytes ignore them
   assign wr_mode = WR && ADDR == ADR_MODE; // see RL20
   assign rd_mode = RD && ADDR == ADR_MODE;
   assign wgate = WDATA[GATE_LSB +: GATE_W];
   assign start_wr = wr_mode && WDATA[BIT_START];
   assign stop_wr = wr_mode && !WDATA[BIT_START];
   assign clr_wr = wr_mode && WDATA[BIT_CLEAR];

   // Mode fields; judge and start status are not stored from writes
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         gate_r <= GATE_RST;
         sel_r <= SEL_RST;
      end
      else if (wr_mode)
      begin
         gate_r <= wgate; // see RL17
         sel_r <= WDATA[SEL_LSB +: SEL_W]; // see RL18
      end
   end

   // Amplifier enables follow the select field, one cycle late
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         fm_en_r <= 1'b0;
         am_en_r <= 1'b0;
      end
      else
      begin
         fm_en_r <= sel_r == SEL_FM; // see RL18
         am_en_r <= sel_r == SEL_AM;
      end
   end

   // **************************************************
   // Reference divider
   // **************************************************
   // Gate periods come from CLK, so gate error tracks the clock error inversely
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ref_cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else if (ref_cnt_r == REF_W'(REF_CYCLES_P - 1))
      begin
         ref_cnt_r <= '0; // see RL14
         tick_r <= 1'b1;
      end
      else
      begin
         ref_cnt_r <= ref_cnt_r + REF_W'(1);
         tick_r <= 1'b0;
      end
   end

   // **************************************************
   // Gate sequencer
   // **************************************************
   // Fixed gate ends on the tick that uses up its last period
   assign expire = !wr_mode && tick_r &&
                   ((state_r == G_OPEN && left_r == TICKS_W'(1)) ||
                    (state_r == G_WAIT && gate_ticks(run_code_r) == '0));

   // Next state; a start write restarts any fixed run
   always_comb
   begin
      state_nxt = state_r;
      left_nxt = left_r;
      unique case (state_r)
         G_IDLE, G_WAIT, G_OPEN:
         begin
            if (start_wr)
               state_nxt = (wgate == GT_SOFT) ? G_SOFT : G_WAIT; // see RL6
            else if (stop_wr || expire)
               state_nxt = G_IDLE; // see RL8
            else if (state_r == G_WAIT && tick_r)
            begin
               state_nxt = G_OPEN; // see RL5
               left_nxt = gate_ticks(run_code_r);
            end
            else if (state_r == G_OPEN && tick_r)
               left_nxt = left_r - TICKS_W'(1);
         end
         G_SOFT:
         begin
            // Soft gate ends by a stop or by choosing a fixed gate time
            if (stop_wr || (wr_mode && wgate != GT_SOFT))
               state_nxt = G_IDLE; // see RL9
         end
      endcase
   end

   // Sequencer registers; the open flag is kept in step with the state
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_r <= G_IDLE;
         left_r <= '0;
         open_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         left_r <= left_nxt;
         open_r <= state_nxt == G_OPEN || state_nxt == G_SOFT; // see RL5
      end
   end

   // Gate code latched at start, so later setup writes do not stretch a run
   always_ff @(posedge CLK)
   begin
      if (RST)
         run_code_r <= GATE_RST;
      else if (start_wr && state_r != G_SOFT)
         run_code_r <= wgate; // see RL17
   end

   // **************************************************
   // Judge flag
   // **************************************************
   // Start outside the soft gate wins over any clear in the same cycle
   always_ff @(posedge CLK)
   begin
      if (RST)
         judge_r <= 1'b0;
      else if (start_wr && state_r != G_SOFT)
         judge_r <= 1'b1; // see RL7
      else if (expire || rd_mode || IRQ_ENTER)
         judge_r <= 1'b0; // see RL8 see RL19
   end

   // **************************************************
   // Count result
   // **************************************************
   // Only edges seen while the gate is open count; clear wins over an event
   always_ff @(posedge CLK)
   begin
      if (RST || clr_wr)
         cnt_r <= '0; // see RL4
      else if (open_r && eif.cnt_pulse)
         cnt_r <= cnt_r + CNT_W'(1); // see RL10 see RL13
   end

   // Clear pulse also restarts the FM prescaler
   always_ff @(posedge CLK)
   begin
      if (RST)
         clr_r <= 1'b0;
      else
         clr_r <= clr_wr;
   end

   assign eif.sel = sel_r;
   assign eif.clr = clr_r;

   // Front end: synchronisers, select and divide-by-four
   ifc_edge u_edge
   (
      .clk (CLK),
      .rst (RST),
      .fm_pin (FM_IN),
      .am_pin (AM_IN),
      .eif (eif.front)
   );

   // **************************************************
   // Read answer
   // **************************************************
   // Data stand only in the cycle after the read strobe
   always_ff @(posedge CLK)
   begin
      if (RST || !RD)
         rdata_r <= RD_IDLE;
      else
         unique case (ADDR)
            ADR_MODE: rdata_r <= {judge_r, state_r != G_IDLE, 1'b0, gate_r, sel_r};
            ADR_CNT_HI: rdata_r <= {HI_FILL, 1'b0, cnt_r[CNT_W-1:16]}; // see RL2
            ADR_CNT_MID: rdata_r <= cnt_r[15:8];
            ADR_CNT_LO: rdata_r <= cnt_r[7:0]; // see RL1
            default: rdata_r <= RD_IDLE;
         endcase
   end

   assign RDATA = rdata_r;
   assign FM_EN = fm_en_r;
   assign AM_EN = am_en_r;
   assign GATE = open_r;

   // **************************************************
   // Checks
   // **************************************************
   // Reference periods spent open, for the gate length check
   always_ff @(posedge CLK)
   begin
      if (RST || state_r != G_OPEN)
         seen_r <= '0;
      else if (tick_r)
         seen_r <= seen_r + TICKS_W'(1);
   end

   property p_len;
      @(posedge CLK) disable iff (RST)
      (expire && state_r == G_OPEN) |-> seen_r + TICKS_W'(1) == gate_ticks(run_code_r);
   endproperty
   a_len: assert property (p_len) else $error("Fixed gate length wrong"); // see RL17

   property p_judge_set;
      @(posedge CLK) disable iff (RST)
      (start_wr && state_r != G_SOFT) |=> judge_r;
   endproperty
   a_judge_set: assert property (p_judge_set) else $error("Judge not set by start"); // see RL7

   property p_clear;
      @(posedge CLK) disable iff (RST)
      clr_wr |=> cnt_r == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("Count not cleared"); // see RL4

   property p_hi_ones;
      @(posedge CLK) disable iff (RST)
      (RD && ADDR == ADR_CNT_HI) |=> RDATA[7:4] == HI_FILL && RDATA[2:0] == $past(cnt_r[CNT_W-1:16]);
   endproperty
   a_hi_ones: assert property (p_hi_ones) else $error("High result byte wrong"); // see RL2

   property p_lo;
      @(posedge CLK) disable iff (RST)
      (RD && ADDR == ADR_CNT_LO) |=> RDATA == $past(cnt_r[7:0]);
   endproperty
   a_lo: assert property (p_lo) else $error("Low result byte wrong"); // see RL1

   property p_soft_open;
      @(posedge CLK) disable iff (RST)
      (start_wr && wgate == GT_SOFT) |=> GATE;
   endproperty
   a_soft_open: assert property (p_soft_open) else $error("Soft gate not open at once"); // see RL6

   property p_wait_tick;
      @(posedge CLK) disable iff (RST)
      (state_r == G_WAIT && !tick_r && !wr_mode) |=> !GATE ##0 state_r == G_WAIT;
   endproperty
   a_wait_tick: assert property (p_wait_tick) else $error("Gate opened before reference edge"); // see RL5

   property p_expire;
      @(posedge CLK) disable iff (RST)
      expire |=> !GATE && !judge_r;
   endproperty
   a_expire: assert property (p_expire) else $error("Gate or judge left after expiry"); // see RL8

   property p_soft_hold;
      @(posedge CLK) disable iff (RST)
      (state_r == G_SOFT && !rd_mode && !IRQ_ENTER) |=> judge_r == $past(judge_r);
   endproperty
   a_soft_hold: assert property (p_soft_hold) else $error("Judge changed in soft gate"); // see RL9

   property p_count;
      @(posedge CLK) disable iff (RST)
      (open_r && eif.cnt_pulse && !clr_wr) |=> cnt_r == $past(cnt_r) + CNT_W'(1);
   endproperty
   a_count: assert property (p_count) else $error("Open gate edge not counted"); // see RL10

   property p_closed;
      @(posedge CLK) disable iff (RST)
      (!open_r && !clr_wr) |=> $stable(cnt_r);
   endproperty
   a_closed: assert property (p_closed) else $error("Count moved with gate closed"); // see RL13

   property p_read_clr;
      @(posedge CLK) disable iff (RST)
      (rd_mode || IRQ_ENTER) && !start_wr |=> !judge_r;
   endproperty
   a_read_clr: assert property (p_read_clr) else $error("Judge not cleared"); // see RL19

   c_fixed: cover property (@(posedge CLK) disable iff (RST) expire);
   c_soft: cover property (@(posedge CLK) disable iff (RST) state_r == G_SOFT ##1 state_r == G_IDLE);
   c_count: cover property (@(posedge CLK) disable iff (RST) open_r && eif.cnt_pulse);
   c_read_hi: cover property (@(posedge CLK) disable iff (RST) RD && ADDR == ADR_CNT_HI);

endmodule : ifc_top

// ---- ifc_if_src.sv ----
// Stand-in for a tuner IF output: free running square wave
`timescale 1ns/1ps
module ifc_if_src
#(
   parameter int HALF = 2 // Half period in clock cycles, two or more
)
(
   input wire logic clk,
   output logic sig
);
   int cnt; // Cycles into this half period
   // One process owns both variables, so each has a single driver
   // Toggles on the falling edge so the counter never sees a race
   initial
   begin
      cnt = 0;
      sig = 1'b0;
      forever
      begin
         @(negedge clk);
         cnt = cnt + 1;
         if (cnt >= HALF)
         begin
            cnt = 0;
            sig = ~sig;
         end
      end
   end
endmodule : ifc_if_src

// ---- ifc_top_test.sv ----
// Self-checking bench of the gated frequency counter
`timescale 1ns/1ps
module ifc_top_test;
   import ifc_pkg::*;
   localparam int REF = 48; // Short reference period keeps runs brief
   logic clk, rst, wr_s, rd_s, irq, fm_in, am_in, fm_en, am_en, gate;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, d;
   logic [CNT_W-1:0] cnt;
   logic [GATE_W-1:0] gts [5] = '{GT_1MS, GT_4MS, GT_8MS, GT_32MS, GT_128MS};
   int mss [5] = '{1, 4, 8, 32, 128}; // Gate lengths in ms
   int mismatches, num_checks, i, w;

   // ***************************
   // Clock, design and sources
   // ***************************
   always #12.5 clk = ~clk;
   ifc_top #(.REF_CYCLES_P(REF)) uut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
      .RD(rd_s), .RDATA(rdata), .FM_IN(fm_in), .AM_IN(am_in), .IRQ_ENTER(irq), .FM_EN(fm_en),
      .AM_EN(am_en), .GATE(gate));
   // FM source: 12 edges per ms; AM source: 8 edges per ms
   ifc_if_src #(.HALF(2)) fm_src (.clk(clk), .sig(fm_in));
   ifc_if_src #(.HALF(3)) am_src (.clk(clk), .sig(am_in));

   // ***************************
   // Tasks
   // ***************************
   function automatic logic [DATA_W-1:0] md(input logic st, input logic cl, input logic [GATE_W-1:0] gt,
      input logic [SEL_W-1:0] sel);
      md = {1'b0, st, cl, gt, sel};
   endfunction : md
   task finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Single-cycle write strobe
   task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      v = rdata;
   endtask : rd
   // Bounded wait for a gate level, counting cycles
   task wait_gate(input logic lvl, input int bound, output int n);
      n = 0;
      while (gate !== lvl)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > bound)
         begin
            mismatches++;
            finish_test();
         end
      end
   endtask : wait_gate
   // No snapshot exists, so bytes are read after the gate closes
   task rd_cnt(output logic [CNT_W-1:0] c);
      rd(ADR_CNT_HI, d);
      chk(d[7:4], 4'hf);
      c[18:16] = d[2:0];
      rd(ADR_CNT_MID, d);
      c[15:8] = d;
      rd(ADR_CNT_LO, d);
      c[7:0] = d;
   endtask : rd_cnt
   // Setup, settle, clear, start, then time the gate
   task run(input logic [GATE_W-1:0] gt, input logic [SEL_W-1:0] sel, input int ms, output logic [CNT_W-1:0] c);
      wr(ADR_MODE, md(1'b0, 1'b0, gt, sel));
      repeat (20) @(posedge clk);
      wr(ADR_MODE, md(1'b0, 1'b1, gt, sel));
      wr(ADR_MODE, md(1'b1, 1'b0, gt, sel));
      wait_gate(1'b1, REF + 4, w);
      chk(w <= REF + 3, 1'b1);
      wait_gate(1'b0, 7000, w);
      chk(w, ms * REF);
      rd(ADR_MODE, d);
      chk(d, md(1'b0, 1'b0, gt, sel));
      rd_cnt(c);
   endtask : run

   // ***************************
   // Main sequence
   // ***************************
   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      irq = 1'b0;
      addr = '0;
      wdata = '0;
      mismatches = 0;
      num_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // Reset values, unmapped and read-only places
      rd(ADR_CNT_HI, d);
      chk(d, 8'hf0);
      rd(ADR_MODE, d);
      chk(d, 8'h00);
      rd(8'h10, d);
      chk(d, 8'h00);
      wr(ADR_CNT_LO, 8'h55);
      rd(ADR_CNT_LO, d);
      chk(d, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         wr(ADR_MODE, md(1'b0, 1'b0, GT_8MS, 2'(i)));
         repeat (2) @(posedge clk);
         #1;
         chk(fm_en, i == 2);
         chk(am_en, i == 3);
      end
      $display("registers done");
      // Every fixed gate code, AM counted undivided; +1 allowed at opening
      for (i = 0; i < 5; i++)
      begin
         run(gts[i], SEL_AM, mss[i], cnt);
         chk(cnt >= 8 * mss[i] && cnt <= 8 * mss[i] + 1, 1'b1);
      end
      // FM divided by four; prescaler phase may shift one either way
      run(GT_4MS, SEL_FM, 4, cnt);
      chk(cnt >= 11 && cnt <= 13, 1'b1);
      wr(ADR_MODE, md(1'b0, 1'b1, GT_4MS, SEL_FM));
      rd_cnt(cnt);
      chk(cnt, 0);
      $display("counting done");
      // Soft gate opens at once and keeps the judge flag
      wr(ADR_MODE, md(1'b1, 1'b0, GT_SOFT, SEL_AM));
      @(posedge clk);
      #1;
      chk(gate, 1'b1);
      repeat (100) @(posedge clk);
      rd(ADR_MODE, d);
      chk(d, md(1'b1, 1'b0, GT_SOFT, SEL_AM) | 8'h80);
      chk(gate, 1'b1);
      rd(ADR_MODE, d);
      chk(d[7], 1'b0);
      // Choosing a fixed gate time alone ends the soft gate
      wr(ADR_MODE, md(1'b1, 1'b0, GT_1MS, SEL_AM));
      @(posedge clk);
      #1;
      chk(gate, 1'b0);
      // Interrupt entry clears the judge flag mid-run
      wr(ADR_MODE, md(1'b0, 1'b1, GT_128MS, SEL_AM));
      wr(ADR_MODE, md(1'b1, 1'b0, GT_128MS, SEL_AM));
      repeat (5) @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      rd(ADR_MODE, d);
      chk(d, md(1'b1, 1'b0, GT_128MS, SEL_AM));
      wr(ADR_MODE, md(1'b0, 1'b0, GT_128MS, SEL_AM));
      // Reserved gate code: run ends at the first tick without opening
      wr(ADR_MODE, md(1'b1, 1'b0, 3'h6, SEL_AM));
      repeat (REF + 2) @(posedge clk);
      rd(ADR_MODE, d);
      chk(d, md(1'b0, 1'b0, 3'h6, SEL_AM));
      $display("gate control done");
      finish_test();
   end
endmodule : ifc_top_test
